// [verilog/cad_datapath.sv]
// Arithmetic and logic execution datapath of the CPU core.
`timescale 1ns/1ps
`include "cad_cfg.svh"
module cad_datapath import cad_pkg::*; (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire cad_op_t     op,
  input  wire cad_mode_t   mode,
  input  wire logic        inFastRam,
  input  wire logic [3:0]  readWaits,
  input  wire logic [3:0]  writeWaits,
  input  wire logic [7:0]  destByte,
  input  wire logic [7:0]  srcByte,
  input  wire logic [15:0] wordIn,
  input  wire logic [15:0] wordImm,
  input  wire logic [7:0]  memByte,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic             busy,
  output logic             done,
  output logic      [7:0]  byteOut,
  output logic             byteWrite,
  output logic      [15:0] wordOut,
  output logic             wordWrite,
  output logic      [7:0]  remOut,
  output logic             remWrite,
  output logic      [7:0]  memOut,
  output logic             memWrite,
  output logic             resultNullFlag,
  output logic             halfCarryFlag,
  output logic             carryFlag,
  output logic      [7:0]  regRdata
);
  cad_alu_if aluBus ();

  cad_state_t  state_reg;
  logic [2:0]  clkSel_reg;
  logic [3:0]  pre_reg;
  logic [5:0]  cnt_reg;
  logic [5:0]  lastClk_reg;
  logic        zero_reg;
  logic        half_reg;
  logic        carry_reg;
  logic        done_reg;
  logic [7:0]  rdata_reg;
  logic [7:0]  resByte_reg;
  logic [15:0] resWord_reg;
  logic [7:0]  resMem_reg;
  logic [2:0]  newFlags_reg;
  logic [2:0]  updFlags_reg;
  logic [3:0]  wrMask_reg;
  logic        useMd_reg;
  logic [7:0]  byteOut_reg;
  logic [15:0] wordOut_reg;
  logic [7:0]  remOut_reg;
  logic [7:0]  memOut_reg;
  logic [3:0]  strobes_reg;

  // Decoded values for the operation being accepted.
  cad_aluop_t  aluOp;
  logic [7:0]  bUse;
  logic        cinUse;
  logic [7:0]  rByte;
  logic [15:0] rWord;
  logic [7:0]  rMem;
  logic        rZ;
  logic        rH;
  logic        rC;
  logic        updZ;
  logic        updH;
  logic        updC;
  logic        wrB;
  logic        wrW;
  logic        wrR;
  logic        wrM;
  logic        useMd;
  logic [16:0] wSum;
  logic [16:0] wDif;
  logic [4:0]  wSumLo;
  logic [4:0]  wDifLo;
  logic [5:0]  baseClk;
  logic [4:0]  extraClk;
  logic [5:0]  totalClk;
  logic        farMode;
  logic        accept;
  logic        finish;
  logic        tick;
  logic [3:0]  divMask;
  logic [2:0]  selClamped;
  logic        wrClkCtl;
  logic        wrStatus;
  logic [7:0]  rdMux;
  logic [15:0] mdWord;
  logic [7:0]  mdRem;
  logic [15:0] finWord;

  cad_alu8 alu (
    .bus (aluBus.unit)
  );

  cad_muldiv md (
    .clock        (clock),
    .rst_n        (rst_n),
    .tick         (tick),
    .start        (accept && useMd),
    .isDivide     (op == OP_WORD_DIVIDE),
    .multiplicand (destByte),
    .operand      (srcByte),
    .dividend     (wordIn),
    .wordResult   (mdWord),
    .remainder    (mdRem)
  );

  // The CPU clock is the core clock divided by a power of two; the prescaler
  // restarts on every accepted operation so counts are exact multiples.
  assign selClamped = (clkSel_reg > `CAD_CLKSEL_MAX) ? `CAD_CLKSEL_MAX : clkSel_reg;
  assign divMask    = (4'h1 << selClamped) - 4'h1;
  assign tick       = (pre_reg & divMask) == divMask;

  assign accept = start && state_reg == ST_IDLE;
  assign finish = state_reg == ST_RUN && tick && cnt_reg == 6'h01;
  assign busy   = state_reg == ST_RUN;

  assign aluBus.a   = destByte;
  assign aluBus.b   = bUse;
  assign aluBus.cin = cinUse;
  assign aluBus.op  = aluOp;

  assign wSum   = {1'b0, wordIn} + {1'b0, wordImm};
  assign wDif   = {1'b0, wordIn} - {1'b0, wordImm};
  assign wSumLo = {1'b0, wordIn[3:0]} + {1'b0, wordImm[3:0]};
  assign wDifLo = {1'b0, wordIn[3:0]} - {1'b0, wordImm[3:0]};

  always_comb begin
    aluOp  = ALU_ADD;
    bUse   = srcByte;
    cinUse = 1'b0;
    rByte  = aluBus.y;
    rWord  = wordIn;
    rMem   = memByte;
    rZ     = aluBus.y == 8'h00;
    rH     = aluBus.hc;
    rC     = aluBus.co;
    updZ   = 1'b1;
    updH   = 1'b1;
    updC   = 1'b1;
    wrB    = 1'b1;
    wrW    = 1'b0;
    wrR    = 1'b0;
    wrM    = 1'b0;
    useMd  = 1'b0;
    case (op)
      OP_ADD: ;
      OP_ADD_WITH_CARRY: cinUse = carry_reg;
      OP_MINUS: aluOp = ALU_SUB;
      OP_MINUS_WITH_BORROW: begin
        aluOp  = ALU_SUB;
        cinUse = carry_reg;
      end
      OP_COMPARE: begin
        aluOp = ALU_SUB;
        wrB   = 1'b0;
      end
      OP_AND, OP_OR, OP_EXCL_OR: begin
        aluOp = (op == OP_AND) ? ALU_AND : (op == OP_OR) ? ALU_OR : ALU_XOR;
        updH  = 1'b0;
        updC  = 1'b0;
      end
      OP_PLUS_ONE, OP_MINUS_ONE: begin
        aluOp = (op == OP_PLUS_ONE) ? ALU_ADD : ALU_SUB;
        bUse  = 8'h01;
        updC  = 1'b0;
      end
      OP_WORD_ADD: begin
        rWord = wSum[15:0];
        rZ    = wSum[15:0] == 16'h0000;
        rH    = wSumLo[4];
        rC    = wSum[16];
        wrB   = 1'b0;
        wrW   = 1'b1;
      end
      OP_WORD_MINUS, OP_WORD_COMPARE: begin
        rWord = wDif[15:0];
        rZ    = wDif[15:0] == 16'h0000;
        rH    = wDifLo[4];
        rC    = wDif[16];
        wrB   = 1'b0;
        wrW   = op == OP_WORD_MINUS;
      end
      OP_WORD_PLUS_ONE, OP_WORD_MINUS_ONE, OP_MULTIPLY, OP_WORD_DIVIDE: begin
        rWord = (op == OP_WORD_PLUS_ONE) ? wordIn + 16'h0001 : wordIn - 16'h0001;
        updZ  = 1'b0;
        updH  = 1'b0;
        updC  = 1'b0;
        wrB   = 1'b0;
        wrW   = 1'b1;
        useMd = op == OP_MULTIPLY || op == OP_WORD_DIVIDE;
        wrR   = op == OP_WORD_DIVIDE;
      end
      OP_ROT_RIGHT, OP_ROT_RIGHT_CARRY: begin
        rByte = {(op == OP_ROT_RIGHT) ? destByte[0] : carry_reg, destByte[7:1]};
        rC    = destByte[0];
        updZ  = 1'b0;
        updH  = 1'b0;
      end
      OP_ROT_LEFT, OP_ROT_LEFT_CARRY: begin
        rByte = {destByte[6:0], (op == OP_ROT_LEFT) ? destByte[7] : carry_reg};
        rC    = destByte[7];
        updZ  = 1'b0;
        updH  = 1'b0;
      end
      OP_NIBBLE_RIGHT: begin
        rByte = {destByte[7:4], memByte[3:0]};
        rMem  = {destByte[3:0], memByte[7:4]};
        wrM   = 1'b1;
        updZ  = 1'b0;
        updH  = 1'b0;
        updC  = 1'b0;
      end
      OP_NIBBLE_LEFT: begin
        rByte = {destByte[7:4], memByte[7:4]};
        rMem  = {memByte[3:0], destByte[3:0]};
        wrM   = 1'b1;
        updZ  = 1'b0;
        updH  = 1'b0;
        updC  = 1'b0;
      end
      default: begin
        updZ = 1'b0;
        updH = 1'b0;
        updC = 1'b0;
        wrB  = 1'b0;
      end
    endcase
  end

  // Instruction length in CPU clocks; slow forms apply outside fast RAM.
  always_comb begin
    case (op)
      OP_WORD_ADD, OP_WORD_MINUS, OP_WORD_COMPARE: baseClk = `CAD_CLK_WORD;
      OP_MULTIPLY: baseClk = `CAD_CLK_MUL;
      OP_WORD_DIVIDE: baseClk = `CAD_CLK_DIV;
      OP_WORD_PLUS_ONE, OP_WORD_MINUS_ONE: baseClk = `CAD_CLK_WSTEP;
      OP_ROT_RIGHT, OP_ROT_LEFT, OP_ROT_RIGHT_CARRY, OP_ROT_LEFT_CARRY:
        baseClk = `CAD_CLK_ROTATE;
      OP_NIBBLE_RIGHT, OP_NIBBLE_LEFT:
        baseClk = inFastRam ? `CAD_CLK_NIB_FAST : `CAD_CLK_NIB_SLOW;
      OP_PLUS_ONE, OP_MINUS_ONE:
        baseClk = (mode == MODE_REG) ? `CAD_CLK_STEP_REG :
                  inFastRam ? `CAD_CLK_STEP_FAST : `CAD_CLK_STEP_SLOW;
      default: begin
        case (mode)
          MODE_REG: baseClk = `CAD_CLK_REG;
          MODE_SADDR_IMM: baseClk = inFastRam ? `CAD_CLK_SIMM_FAST : `CAD_CLK_SIMM_SLOW;
          MODE_SADDR: baseClk = inFastRam ? `CAD_CLK_SDIR_FAST : `CAD_CLK_SDIR_SLOW;
          MODE_PTR: baseClk = inFastRam ? `CAD_CLK_SDIR_FAST : `CAD_CLK_SDIR_SLOW;
          default: baseClk = inFastRam ? `CAD_CLK_FAR_FAST : `CAD_CLK_FAR_SLOW;
        endcase
      end
    endcase
  end

  assign farMode = mode == MODE_ABS || mode == MODE_PTR || mode == MODE_PTR_OFS;

  // Wait states stretch only accesses that leave fast RAM.
  always_comb begin
    extraClk = 5'h00;
    if (!inFastRam) begin
      if (op == OP_NIBBLE_RIGHT || op == OP_NIBBLE_LEFT) begin
        extraClk = {1'b0, readWaits} + {1'b0, writeWaits};
      end else if (wrB && farMode && op != OP_PLUS_ONE && op != OP_MINUS_ONE) begin
        extraClk = {1'b0, readWaits};
      end else if (op == OP_COMPARE && farMode) begin
        extraClk = {1'b0, readWaits};
      end
    end
  end

  assign totalClk = baseClk + {1'b0, extraClk};

  assign wrClkCtl = regWrite && regAddr == `CAD_OFS_CLKCTL;
  assign wrStatus = regWrite && regAddr == `CAD_OFS_STATUS;
  assign rdMux = (regAddr == `CAD_OFS_CLKCTL)  ? {5'h00, clkSel_reg} :
                 (regAddr == `CAD_OFS_STATUS)  ? {4'h0, carry_reg, half_reg, zero_reg, busy} :
                 (regAddr == `CAD_OFS_LASTCLK) ? {2'h0, lastClk_reg} : 8'h00;

  assign finWord = useMd_reg ? mdWord : resWord_reg;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg   <= ST_IDLE;
      cnt_reg     <= 6'h00;
      pre_reg     <= 4'h0;
      clkSel_reg  <= `CAD_CLKSEL_RST;
      lastClk_reg <= 6'h00;
      rdata_reg   <= 8'h00;
    end else begin
      pre_reg   <= accept ? 4'h0 : pre_reg + 4'h1;
      rdata_reg <= regRead ? rdMux : 8'h00;
      if (wrClkCtl) clkSel_reg <= regWdata[2:0];
      case (state_reg)
        ST_IDLE: begin
          if (accept) begin
            state_reg   <= ST_RUN;
            cnt_reg     <= totalClk;
            lastClk_reg <= totalClk;
          end
        end
        ST_RUN: begin
          if (tick) cnt_reg <= cnt_reg - 6'h01;
          if (finish) state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      resByte_reg  <= 8'h00;
      resWord_reg  <= 16'h0000;
      resMem_reg   <= 8'h00;
      newFlags_reg <= 3'h0;
      updFlags_reg <= 3'h0;
      wrMask_reg   <= 4'h0;
      useMd_reg    <= 1'b0;
    end else if (accept) begin
      resByte_reg  <= rByte;
      resWord_reg  <= rWord;
      resMem_reg   <= rMem;
      newFlags_reg <= {rC, rH, rZ};
      updFlags_reg <= {updC, updH, updZ};
      wrMask_reg   <= {wrR, wrM, wrW, wrB};
      useMd_reg    <= useMd;
    end
  end

  // A flag update at completion wins over a software write in the same cycle.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      zero_reg  <= 1'b0;
      half_reg  <= 1'b0;
      carry_reg <= 1'b0;
    end else begin
      if (finish && updFlags_reg[0]) zero_reg <= newFlags_reg[0];
      else if (wrStatus) zero_reg <= regWdata[`CAD_ST_ZERO];
      if (finish && updFlags_reg[1]) half_reg <= newFlags_reg[1];
      else if (wrStatus) half_reg <= regWdata[`CAD_ST_HALF];
      if (finish && updFlags_reg[2]) carry_reg <= newFlags_reg[2];
      else if (wrStatus) carry_reg <= regWdata[`CAD_ST_CARRY];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      done_reg    <= 1'b0;
      strobes_reg <= 4'h0;
      byteOut_reg <= 8'h00;
      wordOut_reg <= 16'h0000;
      remOut_reg  <= 8'h00;
      memOut_reg  <= 8'h00;
    end else begin
      done_reg    <= finish;
      strobes_reg <= finish ? wrMask_reg : 4'h0;
      if (finish) begin
        byteOut_reg <= resByte_reg;
        wordOut_reg <= finWord;
        remOut_reg  <= mdRem;
        memOut_reg  <= resMem_reg;
      end
    end
  end

  assign done           = done_reg;
  assign byteWrite      = strobes_reg[0];
  assign wordWrite      = strobes_reg[1];
  assign memWrite       = strobes_reg[2];
  assign remWrite       = strobes_reg[3];
  assign byteOut        = byteOut_reg;
  assign wordOut        = wordOut_reg;
  assign remOut         = remOut_reg;
  assign memOut         = memOut_reg;
  assign resultNullFlag = zero_reg;
  assign halfCarryFlag  = half_reg;
  assign carryFlag      = carry_reg;
  assign regRdata       = rdata_reg;
endmodule : cad_datapath

// [inc/cad_cfg.svh]
// Constants and offsets of the arithmetic and logic datapath.
`ifndef CAD_CFG_SVH
`define CAD_CFG_SVH
`define CAD_OFS_CLKCTL      8'h00
`define CAD_OFS_STATUS      8'h01
`define CAD_OFS_LASTCLK     8'h02
`define CAD_CLKSEL_RST      3'h0
`define CAD_CLKSEL_MAX      3'h4
`define CAD_ST_BUSY         0
`define CAD_ST_ZERO         1
`define CAD_ST_HALF         2
`define CAD_ST_CARRY        3
`define CAD_CLK_ROTATE      6'h02
`define CAD_CLK_STEP_REG    6'h02
`define CAD_CLK_STEP_FAST   6'h04
`define CAD_CLK_STEP_SLOW   6'h06
`define CAD_CLK_WSTEP       6'h04
`define CAD_CLK_WORD        6'h06
`define CAD_CLK_MUL         6'h10
`define CAD_CLK_DIV         6'h19
`define CAD_CLK_NIB_FAST    6'h0A
`define CAD_CLK_NIB_SLOW    6'h0C
`define CAD_CLK_REG         6'h04
`define CAD_CLK_SIMM_FAST   6'h06
`define CAD_CLK_SIMM_SLOW   6'h08
`define CAD_CLK_SDIR_FAST   6'h04
`define CAD_CLK_SDIR_SLOW   6'h05
`define CAD_CLK_FAR_FAST    6'h08
`define CAD_CLK_FAR_SLOW    6'h09
`define CAD_MUL_STEPS       5'h08
`define CAD_DIV_STEPS       5'h10
`endif

// [inc/cad_pkg.sv]
// Types shared by the arithmetic and logic datapath modules.
package cad_pkg;
  typedef enum logic [4:0] {
    OP_ADD, OP_ADD_WITH_CARRY, OP_MINUS, OP_MINUS_WITH_BORROW,
    OP_AND, OP_OR, OP_EXCL_OR, OP_COMPARE,
    OP_WORD_ADD, OP_WORD_MINUS, OP_WORD_COMPARE, OP_MULTIPLY, OP_WORD_DIVIDE,
    OP_PLUS_ONE, OP_MINUS_ONE, OP_WORD_PLUS_ONE, OP_WORD_MINUS_ONE,
    OP_ROT_RIGHT, OP_ROT_LEFT, OP_ROT_RIGHT_CARRY, OP_ROT_LEFT_CARRY,
    OP_NIBBLE_RIGHT, OP_NIBBLE_LEFT
  } cad_op_t;
  typedef enum logic [2:0] {
    MODE_REG, MODE_SADDR_IMM, MODE_SADDR, MODE_ABS, MODE_PTR, MODE_PTR_OFS
  } cad_mode_t;
  typedef enum logic [2:0] {ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR} cad_aluop_t;
  typedef enum {ST_IDLE, ST_RUN} cad_state_t;
endpackage : cad_pkg

// [inc/cad_alu_if.sv]
// Operand and result bundle between the datapath and its byte ALU.
`timescale 1ns/1ps
interface cad_alu_if;
  import cad_pkg::*;
  logic [7:0] a;
  logic [7:0] b;
  logic       cin;
  cad_aluop_t op;
  logic [7:0] y;
  logic       co;
  logic       hc;
  modport requester (output a, output b, output cin, output op,
                     input y, input co, input hc);
  modport unit (input a, input b, input cin, input op,
                output y, output co, output hc);
endinterface : cad_alu_if

// [verilog/cad_alu8.sv]
// Combinational byte ALU with carry and half carry.
`timescale 1ns/1ps
module cad_alu8 import cad_pkg::*; (
  cad_alu_if.unit bus
);
  logic [8:0] sum9;
  logic [8:0] dif9;
  logic [4:0] sumLo;
  logic [4:0] difLo;

  assign sum9  = {1'b0, bus.a} + {1'b0, bus.b} + {8'h00, bus.cin};
  assign dif9  = {1'b0, bus.a} - {1'b0, bus.b} - {8'h00, bus.cin};
  assign sumLo = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]} + {4'h0, bus.cin};
  assign difLo = {1'b0, bus.a[3:0]} - {1'b0, bus.b[3:0]} - {4'h0, bus.cin};

  always_comb begin
    bus.co = 1'b0;
    bus.hc = 1'b0;
    case (bus.op)
      ALU_ADD: begin
        bus.y  = sum9[7:0];
        bus.co = sum9[8];
        bus.hc = sumLo[4];
      end
      ALU_SUB: begin
        // Bit 8 of the wide difference is the borrow out.
        bus.y  = dif9[7:0];
        bus.co = dif9[8];
        bus.hc = difLo[4];
      end
      ALU_AND: bus.y = bus.a & bus.b;
      ALU_OR:  bus.y = bus.a | bus.b;
      ALU_XOR: bus.y = bus.a ^ bus.b;
      default: bus.y = 8'h00;
    endcase
  end
endmodule : cad_alu8

// [verilog/cad_muldiv.sv]
// Iterative unsigned multiplier and word divider, one step per CPU clock.
`timescale 1ns/1ps
`include "cad_cfg.svh"
module cad_muldiv (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        tick,
  input  wire logic        start,
  input  wire logic        isDivide,
  input  wire logic [7:0]  multiplicand,
  input  wire logic [7:0]  operand,
  input  wire logic [15:0] dividend,
  output logic      [15:0] wordResult,
  output logic      [7:0]  remainder
);
  logic [15:0] acc_reg;
  logic [8:0]  rem_reg;
  logic [7:0]  opnd_reg;
  logic [4:0]  step_reg;
  logic        div_reg;
  logic [8:0]  mulSum;
  logic [8:0]  divShift;
  logic        divFits;
  logic [15:0] acc_next;
  logic [8:0]  rem_next;

  assign mulSum   = {1'b0, acc_reg[15:8]} + (acc_reg[0] ? {1'b0, opnd_reg} : 9'h000);
  assign divShift = {rem_reg[7:0], acc_reg[15]};
  // A zero divisor always fits, so the quotient saturates to all ones and
  // the remainder ends as the dividend's low byte, in the usual step count.
  assign divFits  = divShift >= {1'b0, opnd_reg};
  assign acc_next = div_reg ? {acc_reg[14:0], divFits} : {mulSum, acc_reg[7:1]};
  assign rem_next = div_reg ? (divFits ? divShift - {1'b0, opnd_reg} : divShift) : rem_reg;
  assign wordResult = acc_reg;
  assign remainder  = rem_reg[7:0];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg  <= 16'h0000;
      rem_reg  <= 9'h000;
      opnd_reg <= 8'h00;
      step_reg <= 5'h00;
      div_reg  <= 1'b0;
    end else if (start) begin
      acc_reg  <= isDivide ? dividend : {8'h00, multiplicand};
      rem_reg  <= 9'h000;
      opnd_reg <= operand;
      div_reg  <= isDivide;
      step_reg <= isDivide ? `CAD_DIV_STEPS : `CAD_MUL_STEPS;
    end else if (tick && step_reg != 5'h00) begin
      acc_reg  <= acc_next;
      rem_reg  <= rem_next;
      step_reg <= step_reg - 5'h01;
    end
  end
endmodule : cad_muldiv

// [sim/cad_datapath_sva.sv]
// Concurrent checks on the datapath top ports.
`timescale 1ns/1ps
module cad_datapath_sva import cad_pkg::*; (
  input logic       clock,
  input logic       rst_n,
  input logic       start,
  input cad_op_t    op,
  input logic       busy,
  input logic       done,
  input logic       byteWrite,
  input logic       wordWrite,
  input logic       resultNullFlag,
  input logic       halfCarryFlag,
  input logic       carryFlag,
  input logic       regWrite,
  input logic [7:0] regAddr,
  input logic [7:0] regWdata
);
  logic [9:0] cntReg;
  logic [2:0] selReg;
  logic [2:0] flagsReg;
  cad_op_t    opReg;
  wire  [2:0] flagsNow = {resultNullFlag, halfCarryFlag, carryFlag};
  wire        accepted = start && !busy;
  // Selections above four run at the slowest rate.
  wire  [2:0] selClamp = (selReg > 3'h4) ? 3'h4 : selReg;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cntReg <= 10'h000;
      selReg <= 3'h0;
      flagsReg <= 3'h0;
      opReg <= OP_ADD;
    end else begin
      cntReg <= accepted ? 10'h001 : cntReg + 10'h001;
      if (regWrite && regAddr == 8'h00) begin
        selReg <= regWdata[2:0];
      end
      if (accepted) begin
        flagsReg <= flagsNow;
        opReg <= op;
      end
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_cmp_nowrite;
    done && opReg == OP_COMPARE |-> !byteWrite;
  endproperty
  a_cmp_nowrite: assert property (p_cmp_nowrite) else $error("compare stored a byte");
  property p_wcmp_nowrite;
    done && opReg == OP_WORD_COMPARE |-> !wordWrite;
  endproperty
  a_wcmp_nowrite: assert property (p_wcmp_nowrite) else $error("word compare stored");
  property p_mul_time;
    done && opReg == OP_MULTIPLY |-> cntReg == (10'h010 << selClamp) + 10'h001;
  endproperty
  a_mul_time: assert property (p_mul_time) else $error("multiply length wrong");
  property p_div_time;
    done && opReg == OP_WORD_DIVIDE |-> cntReg == (10'h019 << selClamp) + 10'h001;
  endproperty
  a_div_time: assert property (p_div_time) else $error("divide length wrong");
  property p_wstep_time;
    accepted && op inside {OP_WORD_PLUS_ONE, OP_WORD_MINUS_ONE} && selReg == 3'h0
      |=> busy [*4] ##1 done;
  endproperty
  a_wstep_time: assert property (p_wstep_time) else $error("word step length wrong");
  property p_rot_time;
    done && opReg inside {OP_ROT_RIGHT, OP_ROT_LEFT, OP_ROT_RIGHT_CARRY, OP_ROT_LEFT_CARRY}
      |-> cntReg == (10'h002 << selClamp) + 10'h001;
  endproperty
  a_rot_time: assert property (p_rot_time) else $error("rotate length wrong");
  property p_keep_flags;
    done && opReg inside {OP_MULTIPLY, OP_WORD_DIVIDE, OP_WORD_PLUS_ONE, OP_WORD_MINUS_ONE,
      OP_NIBBLE_RIGHT, OP_NIBBLE_LEFT} |-> flagsNow == flagsReg;
  endproperty
  a_keep_flags: assert property (p_keep_flags) else $error("flags changed");
  property p_logic_flags;
    done && opReg inside {OP_AND, OP_OR, OP_EXCL_OR} |-> flagsNow[1:0] == flagsReg[1:0];
  endproperty
  a_logic_flags: assert property (p_logic_flags) else $error("logic op moved carry");
  property p_step_carry;
    done && opReg inside {OP_PLUS_ONE, OP_MINUS_ONE} |-> carryFlag == flagsReg[0];
  endproperty
  a_step_carry: assert property (p_step_carry) else $error("step moved carry");
endmodule : cad_datapath_sva

// [sim/cad_mem_model.sv]
// Data memory byte at the far side, answering fast or with wait states.
`timescale 1ns/1ps
module cad_mem_model #(parameter logic [7:0] INIT = 8'h5A) (
  input  logic       clock,
  input  logic       rst_n,
  input  logic       slow,
  input  logic       memWrite,
  input  logic [7:0] memOut,
  output logic [7:0] memByte,
  output logic       inFastRam,
  output logic [3:0] readWaits,
  output logic [3:0] writeWaits
);
  assign inFastRam = !slow;
  assign readWaits = slow ? 4'h3 : 4'h0;
  assign writeWaits = slow ? 4'h3 : 4'h0;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      memByte <= INIT;
    end else if (memWrite) begin
      memByte <= memOut;
    end
  end
endmodule : cad_mem_model

// [sim/tb_top.sv]
// Self-checking bench for the arithmetic and logic datapath.
`timescale 1ns/1ps
module tb_top import cad_pkg::*;;
  logic        clock, rst_n, start, regWrite, regRead, slow, inFastRam, busy, done;
  logic        byteWrite, wordWrite, remWrite, memWrite;
  logic        resultNullFlag, halfCarryFlag, carryFlag;
  cad_op_t     op;
  cad_mode_t   mode;
  logic [7:0]  destByte, srcByte, regAddr, regWdata, memByte, memOut, byteOut, remOut, regRdata;
  logic [15:0] wordIn, wordImm, wordOut;
  logic [3:0]  readWaits, writeWaits;
  int          nFail, nChecks;
  cad_datapath i_dut (.clock, .rst_n, .start, .op, .mode, .inFastRam, .readWaits, .writeWaits,
    .destByte, .srcByte, .wordIn, .wordImm, .memByte, .regAddr, .regWdata, .regWrite, .regRead,
    .busy, .done, .byteOut, .byteWrite, .wordOut, .wordWrite, .remOut, .remWrite, .memOut,
    .memWrite, .resultNullFlag, .halfCarryFlag, .carryFlag, .regRdata);
  cad_mem_model i_mem (.clock, .rst_n, .slow, .memWrite, .memOut, .memByte, .inFastRam,
    .readWaits, .writeWaits);
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    nChecks++;
    if (g !== e) begin
      nFail++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic res(logic [7:0] b, logic [2:0] f);
    chk("byteOut", b, byteOut);
    chk("flags", f, {resultNullFlag, halfCarryFlag, carryFlag});
  endtask : res
  task automatic wr(logic [7:0] a, logic [7:0] v);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= v;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    chk("regRdata", e, regRdata);
  endtask : rd
  // The launch counts as cycle zero, so a count of n ends with done in cycle n + 1.
  task automatic run(cad_op_t o, cad_mode_t m, int n, logic [7:0] d = 8'h00, s = 8'h00,
                     logic [15:0] w = 16'h0000, i = 16'h0000);
    int k;
    @(posedge clock);
    start <= 1'b1;
    op <= o;
    mode <= m;
    destByte <= d;
    srcByte <= s;
    wordIn <= w;
    wordImm <= i;
    @(posedge clock);
    start <= 1'b0;
    k = 1;
    #1;
    while (done !== 1'b1 && k < 500) begin
      @(posedge clock);
      #1;
      k++;
    end
    chk("cycles", n + 1, k);
  endtask : run
  task automatic t_regs;
    rd(8'h00, 8'h00);
    rd(8'h01, 8'h00);
    wr(8'h07, 8'hFF);
    rd(8'h07, 8'h00);
  endtask : t_regs
  task automatic t_clock;
    wr(8'h00, 8'h01);
    rd(8'h00, 8'h01);
    run(OP_ROT_RIGHT, MODE_REG, 4, 8'h01);
    res(8'h80, 3'b001);
    rd(8'h02, 8'h02);
    wr(8'h00, 8'h00);
  endtask : t_clock
  task automatic t_add_sub;
    wr(8'h01, 8'h08);
    run(OP_ADD_WITH_CARRY, MODE_REG, 4, 8'h0F, 8'h00);
    res(8'h10, 3'b010);
    run(OP_ADD_WITH_CARRY, MODE_REG, 4, 8'hFF, 8'h01);
    res(8'h00, 3'b111);
    run(OP_MINUS, MODE_REG, 4, 8'h00, 8'h01);
    res(8'hFF, 3'b011);
    run(OP_MINUS_WITH_BORROW, MODE_REG, 4, 8'h10, 8'h0F);
    res(8'h00, 3'b110);
    run(OP_COMPARE, MODE_REG, 4, 8'h05, 8'h05);
    chk("byteWrite", 1'b0, byteWrite);
  endtask : t_add_sub
  task automatic t_logic;
    cad_op_t    ops[3] = '{OP_AND, OP_OR, OP_EXCL_OR};
    logic [7:0] exp[3] = '{8'h00, 8'hFF, 8'h00};
    wr(8'h01, 8'h0C);
    foreach (ops[j]) begin
      run(ops[j], MODE_REG, 4, 8'hF0, (j == 2) ? 8'hF0 : 8'h0F);
      res(exp[j], {exp[j] == 8'h00, 2'b11});
    end
  endtask : t_logic
  task automatic t_word;
    run(OP_WORD_ADD, MODE_REG, 6, , , 16'hFFFF, 16'h0001);
    res(byteOut, 3'b111);
    chk("wordOut", 16'h0000, wordOut);
    run(OP_WORD_MINUS, MODE_REG, 6, , , 16'h0100, 16'h0001);
    res(byteOut, 3'b010);
    chk("wordOut", 16'h00FF, wordOut);
    run(OP_WORD_COMPARE, MODE_REG, 6, , , 16'h1234, 16'h1234);
    res(byteOut, 3'b100);
    chk("wordWrite", 1'b0, wordWrite);
  endtask : t_word
  task automatic t_muldiv;
    run(OP_MULTIPLY, MODE_REG, 16, 8'hFF, 8'hFF);
    chk("wordOut", 16'hFE01, wordOut);
    run(OP_WORD_DIVIDE, MODE_REG, 25, , 8'h10, 16'h1234);
    chk("wordOut", 16'h0123, wordOut);
    chk("remOut", 8'h04, remOut);
    chk("remWrite", 1'b1, remWrite);
    run(OP_WORD_DIVIDE, MODE_REG, 25, , 8'h00, 16'h1234);
    chk("wordOut", 16'hFFFF, wordOut);
    chk("remOut", 8'h34, remOut);
    res(byteOut, 3'b100);
  endtask : t_muldiv
  task automatic t_incdec;
    wr(8'h01, 8'h08);
    run(OP_PLUS_ONE, MODE_REG, 2, 8'hFF);
    res(8'h00, 3'b111);
    run(OP_MINUS_ONE, MODE_SADDR, 4, 8'h10);
    res(8'h0F, 3'b011);
    run(OP_WORD_PLUS_ONE, MODE_REG, 4, , , 16'hFFFF);
    chk("wordOut", 16'h0000, wordOut);
    run(OP_WORD_MINUS_ONE, MODE_REG, 4, , , 16'h0000);
    chk("wordOut", 16'hFFFF, wordOut);
    res(byteOut, 3'b011);
  endtask : t_incdec
  task automatic t_rotate;
    cad_op_t    ro[4] = '{OP_ROT_RIGHT, OP_ROT_LEFT, OP_ROT_RIGHT_CARRY, OP_ROT_LEFT_CARRY};
    logic [7:0] ri[4] = '{8'h01, 8'h80, 8'h02, 8'h80};
    logic [7:0] rx[4] = '{8'h80, 8'h01, 8'h81, 8'h00};
    logic [3:0] rc = 4'hB;
    wr(8'h01, 8'h00);
    foreach (ro[j]) begin
      run(ro[j], MODE_REG, 2, ri[j]);
      res(rx[j], {2'b00, rc[j]});
    end
  endtask : t_rotate
  task automatic t_nibble;
    run(OP_NIBBLE_RIGHT, MODE_PTR, 10, 8'h3C);
    res(8'h3A, 3'b001);
    chk("memOut", 8'hC5, memOut);
    chk("memWrite", 1'b1, memWrite);
    @(posedge clock);
    slow <= 1'b1;
    run(OP_NIBBLE_LEFT, MODE_PTR, 18, 8'h3C);
    res(8'h3C, 3'b001);
    @(posedge clock);
    #1;
    chk("memByte", 8'h5C, memByte);
  endtask : t_nibble
  task automatic t_wait;
    run(OP_ADD_WITH_CARRY, MODE_PTR, 8, 8'h01, 8'h01);
    res(8'h03, 3'b000);
    run(OP_ADD, MODE_SADDR_IMM, 8, 8'h01, 8'h01);
    res(8'h02, 3'b000);
    run(OP_AND, MODE_ABS, 12, 8'hFF, 8'h0F);
    @(posedge clock);
    slow <= 1'b0;
    run(OP_AND, MODE_PTR_OFS, 8, 8'hFF, 8'h0F);
    res(8'h0F, 3'b000);
  endtask : t_wait
  task automatic print_verdict;
    $display("checks %0d errors %0d", nChecks, nFail);
    if (nFail == 0 && nChecks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    {rst_n, start, regWrite, regRead, slow} = 5'h00;
    {destByte, srcByte, regAddr, regWdata, wordIn, wordImm} = 64'h0;
    op = OP_ADD;
    mode = MODE_REG;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    t_regs;
    t_clock;
    t_add_sub;
    t_logic;
    t_word;
    t_muldiv;
    t_incdec;
    t_rotate;
    t_nibble;
    t_wait;
    print_verdict;
  end
  // All scenarios need under a thousand cycles.
  initial begin
    repeat (5000) @(posedge clock);
    nFail++;
    print_verdict;
  end
endmodule : tb_top
bind cad_datapath cad_datapath_sva i_sva (.clock, .rst_n, .start, .op, .busy, .done, .byteWrite,
  .wordWrite, .resultNullFlag, .halfCarryFlag, .carryFlag, .regWrite, .regAddr, .regWdata);
